// >>> sbl_pkg.sv
// Shared constants, bus map and state encodings of the serial boot loader.
// Assumes a single 200 MHz core clock and a classic Wishbone register port.
package sbl_pkg;
  // ---------------------------------------------------------------------------
  // Clock, timing and serial framing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int READY_STATES = 100;
  localparam int STATE_PER_CYCLE = 1;
  localparam logic [15:0] READY_CYCLES = 16'(READY_STATES * STATE_PER_CYCLE);
  localparam logic [1:0] SYNC_CYCLES = 2'h2;
  localparam logic [3:0] LOW_BITS_LAST = 4'h8;
  localparam logic [2:0] DATA_BIT_LAST = 3'h7;
  localparam logic [3:0] FRAME_BIT_LAST = 4'h9;
  localparam logic [2:0] BOOT_MODE_CODE = 3'h3;

  // ---------------------------------------------------------------------------
  // Protocol bytes and boot RAM window
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BYTE_ADJ = 8'h00;
  localparam logic [7:0] BYTE_SYNC = 8'h55;
  localparam logic [7:0] BYTE_ACK = 8'hAA;
  localparam logic [7:0] BYTE_FAIL = 8'hFF;
  localparam logic [23:0] BOOT_RAM_BASE = 24'hFFE800;
  localparam logic [23:0] BOOT_RAM_LAST = 24'hFFEFBF;
  localparam int BOOT_RAM_DEPTH = int'(BOOT_RAM_LAST - BOOT_RAM_BASE) + 1;
  localparam int BOOT_RAM_AW = 11;

  // ---------------------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------------------
  localparam int WB_AW = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_DIVISOR = 8'h04;
  localparam logic [7:0] REG_LENGTH = 8'h08;
  localparam logic [7:0] REG_RAM_ADDR = 8'h0C;
  localparam logic [7:0] REG_RAM_DATA = 8'h10;

  // ---------------------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_SETTLE, ST_USER, ST_WAIT_READY, ST_WAIT_HIGH, ST_MEASURE, ST_SEND_ADJ,
    ST_WAIT_SYNC, ST_SEND_ACK, ST_LEN_HI, ST_LEN_LO, ST_LOAD, ST_ERASE_CHK,
    ST_ERASE_WAIT, ST_SEND_RESULT, ST_DRAIN, ST_BRANCH, ST_ABORT, ST_EXIT
  } sbl_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sbl_rx_state_t;
endpackage

// >>> sbl_core_if.sv
// Carrier between the boot loader core, its serial engine and its RAM.
// Assumes all three parties run on the same core clock.
interface sbl_core_if #(parameter int AW = 11) ();
  logic rx_level;
  logic rx_en;
  logic tx_en;
  logic [15:0] divisor;
  logic tx_start;
  logic [7:0] tx_data;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  logic txd;
  logic ram_we;
  logic [AW-1:0] ram_waddr;
  logic [AW-1:0] ram_raddr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  modport core (output rx_level, rx_en, tx_en, divisor, tx_start, tx_data, ram_we, ram_waddr,
                ram_raddr, ram_wdata, input tx_busy, rx_valid, rx_data, txd, ram_rdata);
  modport uart (input rx_level, rx_en, tx_en, divisor, tx_start, tx_data,
                output tx_busy, rx_valid, rx_data, txd);
  modport ram (input ram_we, ram_waddr, ram_raddr, ram_wdata, output ram_rdata);
endinterface

// >>> sbl_ram.sv
// Boot program store: one write port and one registered read port.
// Assumes the core never writes beyond the depth it was built with.
module sbl_ram #(
  parameter int DEPTH = sbl_pkg::BOOT_RAM_DEPTH
) (
  input wire logic core_clk,
  sbl_core_if.ram bus
);
  import sbl_pkg::*;
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_reg;

  // Neither the array nor the read register has a reset.
  always_ff @(posedge core_clk) begin
    if (bus.ram_we) begin
      mem[bus.ram_waddr] <= bus.ram_wdata;
    end
    rdata_reg <= mem[bus.ram_raddr];
  end

  assign bus.ram_rdata = rdata_reg;
endmodule // sbl_ram

// >>> sbl_uart.sv
// Serial engine: 8 data bits, no parity, one stop bit, divisor in clocks per bit.
// Assumes the receive level is already synchronised by the core.
module sbl_uart (
  input wire logic core_clk,
  input wire logic nrst,
  sbl_core_if.uart bus
);
  import sbl_pkg::*;
  typedef struct packed {
    sbl_rx_state_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_valid;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_shift;
    logic txd;
  } sbl_uart_t;
  sbl_uart_t r_reg, r_next;

  // Receiver samples mid-bit, transmitter shifts a ten-bit frame lsb first.
  always_comb begin
    r_next = r_reg;
    r_next.rx_valid = 1'b0;
    if (!bus.rx_en) begin
      r_next.rx_st = RX_IDLE;
    end else if (r_reg.rx_st == RX_IDLE) begin
      if (!bus.rx_level) begin
        r_next.rx_st = RX_START;
        r_next.rx_cnt = bus.divisor >> 1;
      end
    end else if (r_reg.rx_cnt != 16'h0000) begin
      r_next.rx_cnt = r_reg.rx_cnt - 16'h0001;
    end else begin
      r_next.rx_cnt = bus.divisor - 16'h0001;
      case (r_reg.rx_st)
        RX_START: begin
          r_next.rx_st = bus.rx_level ? RX_IDLE : RX_DATA;
          r_next.rx_bit = 3'h0;
        end
        RX_DATA: begin
          r_next.rx_shift = {bus.rx_level, r_reg.rx_shift[7:1]};
          r_next.rx_bit = r_reg.rx_bit + 3'h1;
          if (r_reg.rx_bit == DATA_BIT_LAST) begin
            r_next.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          r_next.rx_valid = bus.rx_level; // A framing error drops the byte.
          r_next.rx_st = RX_IDLE;
        end
        default: r_next.rx_st = RX_IDLE;
      endcase
    end
    if (!bus.tx_en) begin
      r_next.tx_busy = 1'b0;
      r_next.txd = 1'b1;
    end else if (!r_reg.tx_busy) begin
      r_next.txd = 1'b1;
      if (bus.tx_start) begin
        r_next.tx_busy = 1'b1;
        r_next.tx_shift = {1'b1, bus.tx_data, 1'b0};
        r_next.tx_bit = 4'h0;
        r_next.tx_cnt = bus.divisor - 16'h0001;
        r_next.txd = 1'b0;
      end
    end else if (r_reg.tx_cnt != 16'h0000) begin
      r_next.tx_cnt = r_reg.tx_cnt - 16'h0001;
    end else if (r_reg.tx_bit == FRAME_BIT_LAST) begin
      r_next.tx_busy = 1'b0;
      r_next.txd = 1'b1;
    end else begin
      r_next.tx_cnt = bus.divisor - 16'h0001;
      r_next.tx_bit = r_reg.tx_bit + 4'h1;
      r_next.tx_shift = {1'b1, r_reg.tx_shift[9:1]};
      r_next.txd = r_reg.tx_shift[1];
    end
  end

  // State register; the line idles high out of reset.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '{rx_st: RX_IDLE, txd: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.rx_valid = r_reg.rx_valid;
  assign bus.rx_data = r_reg.rx_shift;
  assign bus.tx_busy = r_reg.tx_busy;
  assign bus.txd = r_reg.txd;
endmodule // sbl_uart

// >>> sbl_loader.sv
// Boot loader top: mode decode, bit rate matching, program load, erase and branch.
// Assumes a Wishbone classic master on core_clk and flash erase logic on core_clk.
//
// Chosen here: register access over Wishbone and the register offsets.
module sbl_loader (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sbl_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_pin,
  output logic txd_pin_o,
  output logic txd_pin_oe,
  input wire logic [2:0] mode_select_pins,
  input wire logic flash_write_enable_pin,
  input wire logic watchdog_overflow,
  input wire logic flash_has_data,
  input wire logic flash_erase_done,
  input wire logic flash_erase_fail,
  output logic flash_erase_req,
  output logic interrupt_mask,
  output logic boot_active,
  output logic branch_go,
  output logic [23:0] branch_addr
);
  import sbl_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    sbl_state_t st;
    logic [15:0] cnt;
    logic [3:0] sub9;
    logic [15:0] div_acc;
    logic [15:0] divisor;
    logic [15:0] length;
    logic [15:0] index;
    logic rx_en;
    logic tx_en;
    logic tx_pend;
    logic tx_start;
    logic [7:0] tx_byte;
    logic ram_we;
    logic [BOOT_RAM_AW-1:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic [BOOT_RAM_AW-1:0] ram_raddr;
    logic erase_req;
    logic erase_err;
    logic adjusted;
    logic loaded;
    logic branch;
    logic txd_oe;
    logic irq_mask;
    logic boot;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] rxd_sync;
    logic [3:0] mode_sync1;
    logic [3:0] mode_sync2;
  } sbl_loader_t;
  sbl_loader_t r_reg, r_next;

  sbl_core_if #(.AW(BOOT_RAM_AW)) bus ();

  sbl_uart u_uart (
    .core_clk(core_clk),
    .nrst(nrst),
    .bus(bus.uart)
  );

  sbl_ram #(.DEPTH(BOOT_RAM_DEPTH)) u_ram (
    .core_clk(core_clk),
    .bus(bus.ram)
  );

  // Queue one byte for the serial engine; a second one before it starts replaces the first.
  function automatic sbl_loader_t send(input sbl_loader_t s, input logic [7:0] b);
    send = s;
    send.tx_pend = 1'b1;
    send.tx_byte = b;
  endfunction

  // States in which boot mode is live and the watchdog can end it.
  function automatic logic in_boot(input sbl_state_t s);
    in_boot = !(s inside {ST_SETTLE, ST_USER, ST_BRANCH, ST_ABORT, ST_EXIT});
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Synchronisers, sequencer, transmit launch and the Wishbone slave.
  always_comb begin
    r_next = r_reg;
    r_next.rxd_sync = {r_reg.rxd_sync[0], rxd_pin};
    r_next.mode_sync1 = {mode_select_pins, flash_write_enable_pin};
    r_next.mode_sync2 = r_reg.mode_sync1;
    r_next.ram_we = 1'b0;
    r_next.tx_start = 1'b0;
    if (r_reg.tx_pend && !r_reg.tx_start && !bus.tx_busy) begin
      r_next.tx_start = 1'b1;
      r_next.tx_pend = 1'b0;
    end
    case (r_reg.st)
      ST_SETTLE: begin
        // Pins are judged once the synchroniser has filled after release.
        r_next.cnt = r_reg.cnt + 16'h0001;
        if (r_reg.cnt == 16'(SYNC_CYCLES)) begin
          r_next.cnt = 16'h0000;
          if (r_reg.mode_sync2 == {BOOT_MODE_CODE, 1'b1}) begin
            r_next.st = ST_WAIT_READY;
            r_next.boot = 1'b1;
            r_next.irq_mask = 1'b1;
            r_next.txd_oe = 1'b1;
          end else begin
            r_next.st = ST_USER;
          end
        end
      end
      ST_WAIT_READY: begin
        r_next.cnt = r_reg.cnt + 16'h0001;
        if (r_reg.cnt == READY_CYCLES - 16'h0001) begin
          r_next.st = ST_WAIT_HIGH;
        end
      end
      ST_WAIT_HIGH: begin
        // Start on a clean falling edge so a byte caught midway is not timed.
        r_next.sub9 = 4'h0;
        r_next.div_acc = 16'h0000;
        if (r_reg.rxd_sync[1]) begin
          r_next.st = ST_MEASURE;
          r_next.cnt = 16'h0000;
        end
      end
      ST_MEASURE: begin
        // Start bit plus eight zero data bits give nine bit times low.
        if (!r_reg.rxd_sync[1]) begin
          r_next.cnt = 16'h0001;
          r_next.sub9 = (r_reg.sub9 == LOW_BITS_LAST) ? 4'h0 : r_reg.sub9 + 4'h1;
          if (r_reg.sub9 == LOW_BITS_LAST) begin
            r_next.div_acc = r_reg.div_acc + 16'h0001;
          end
        end else if (r_reg.cnt != 16'h0000) begin
          if (r_reg.div_acc == 16'h0000) begin
            r_next.st = ST_WAIT_HIGH; // Too short to be a zero byte.
          end else begin
            r_next.divisor = r_reg.div_acc;
            r_next.rx_en = 1'b1;
            r_next.tx_en = 1'b1;
            r_next.adjusted = 1'b1;
            r_next.st = ST_SEND_ADJ;
          end
        end
      end
      ST_SEND_ADJ: begin
        r_next = send(r_next, BYTE_ADJ);
        r_next.st = ST_WAIT_SYNC;
      end
      ST_WAIT_SYNC: begin
        // Further zero bytes from the host are simply passed over.
        if (bus.rx_valid && bus.rx_data == BYTE_SYNC) begin
          r_next = send(r_next, BYTE_ACK);
          r_next.st = ST_SEND_ACK;
        end
      end
      ST_SEND_ACK: begin
        r_next.st = ST_LEN_HI;
      end
      ST_LEN_HI: begin
        if (bus.rx_valid) begin
          r_next.length[15:8] = bus.rx_data;
          r_next = send(r_next, bus.rx_data);
          r_next.st = ST_LEN_LO;
        end
      end
      ST_LEN_LO: begin
        if (bus.rx_valid) begin
          r_next.length[7:0] = bus.rx_data;
          r_next = send(r_next, bus.rx_data);
          r_next.index = 16'h0000;
          r_next.st = ({r_reg.length[15:8], bus.rx_data} == 16'h0000) ? ST_ERASE_CHK : ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (bus.rx_valid) begin
          r_next = send(r_next, bus.rx_data);
          // Bytes past the window are echoed but not stored.
          if (r_reg.index < 16'(BOOT_RAM_DEPTH)) begin
            r_next.ram_we = 1'b1;
            r_next.ram_waddr = r_reg.index[BOOT_RAM_AW-1:0];
            r_next.ram_wdata = bus.rx_data;
          end
          r_next.index = r_reg.index + 16'h0001;
          if (r_reg.index == r_reg.length - 16'h0001) begin
            r_next.st = ST_ERASE_CHK;
          end
        end
      end
      ST_ERASE_CHK: begin
        r_next.loaded = 1'b1;
        if (flash_has_data) begin
          r_next.erase_req = 1'b1;
          r_next.st = ST_ERASE_WAIT;
        end else begin
          r_next = send(r_next, BYTE_ACK);
          r_next.st = ST_SEND_RESULT;
        end
      end
      ST_ERASE_WAIT: begin
        if (flash_erase_fail) begin
          r_next.erase_req = 1'b0;
          r_next.erase_err = 1'b1;
          r_next = send(r_next, BYTE_FAIL);
          r_next.st = ST_SEND_RESULT;
        end else if (flash_erase_done) begin
          r_next.erase_req = 1'b0;
          r_next = send(r_next, BYTE_ACK);
          r_next.st = ST_SEND_RESULT;
        end
      end
      ST_SEND_RESULT: begin
        r_next.st = ST_DRAIN;
      end
      ST_DRAIN: begin
        // The result byte must leave the line before the engine is stopped.
        if (!r_reg.tx_pend && !r_reg.tx_start && !bus.tx_busy) begin
          r_next.rx_en = 1'b0;
          r_next.tx_en = 1'b0;
          r_next.st = r_reg.erase_err ? ST_ABORT : ST_BRANCH;
          r_next.branch = !r_reg.erase_err;
          r_next.irq_mask = r_reg.erase_err;
        end
      end
      ST_USER, ST_BRANCH, ST_ABORT, ST_EXIT: begin
        r_next.st = r_reg.st;
      end
      default: r_next.st = ST_EXIT;
    endcase
    if (in_boot(r_reg.st) && watchdog_overflow) begin
      r_next.st = ST_EXIT;
      r_next.boot = 1'b0;
      r_next.rx_en = 1'b0;
      r_next.tx_en = 1'b0;
      r_next.tx_pend = 1'b0;
      r_next.erase_req = 1'b0;
      r_next.irq_mask = 1'b0;
      r_next.txd_oe = 1'b0;
    end
    // Wishbone: ack one cycle after the strobe, then dropped for a cycle.
    r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
    r_next.rdata = 32'h00000000;
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      if (wb_we_i && wb_adr_i == REG_RAM_ADDR) begin
        if (wb_sel_i[0]) begin
          r_next.ram_raddr[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          r_next.ram_raddr[BOOT_RAM_AW-1:8] = wb_dat_i[BOOT_RAM_AW-1:8];
        end
      end
      case (wb_adr_i)
        REG_STATUS: r_next.rdata[5:0] = {r_reg.branch, r_reg.erase_err, r_reg.loaded, r_reg.adjusted,
                                         r_reg.st == ST_EXIT, r_reg.boot};
        REG_DIVISOR: r_next.rdata[15:0] = r_reg.divisor;
        REG_LENGTH: r_next.rdata = {r_reg.index, r_reg.length};
        REG_RAM_ADDR: r_next.rdata[BOOT_RAM_AW-1:0] = r_reg.ram_raddr;
        REG_RAM_DATA: r_next.rdata[7:0] = bus.ram_rdata;
        default: r_next.rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------------------
  // One register for all state; reset holds only constants.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '{st: ST_SETTLE, rxd_sync: 2'h3, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.rx_level = r_reg.rxd_sync[1];
  assign bus.rx_en = r_reg.rx_en;
  assign bus.tx_en = r_reg.tx_en;
  assign bus.divisor = r_reg.divisor;
  assign bus.tx_start = r_reg.tx_start;
  assign bus.tx_data = r_reg.tx_byte;
  assign bus.ram_we = r_reg.ram_we;
  assign bus.ram_waddr = r_reg.ram_waddr;
  assign bus.ram_wdata = r_reg.ram_wdata;
  assign bus.ram_raddr = r_reg.ram_raddr;
  assign wb_dat_o = r_reg.rdata;
  assign wb_ack_o = r_reg.ack;
  assign txd_pin_o = bus.txd;
  assign txd_pin_oe = r_reg.txd_oe;
  assign flash_erase_req = r_reg.erase_req;
  assign interrupt_mask = r_reg.irq_mask;
  assign boot_active = r_reg.boot;
  assign branch_go = r_reg.branch;
  assign branch_addr = BOOT_RAM_BASE;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_user_entry: assert property (@(posedge core_clk) disable iff (!nrst)
    (r_reg.st == ST_SETTLE && r_reg.cnt == 16'(SYNC_CYCLES) && r_reg.mode_sync2 != {BOOT_MODE_CODE, 1'b1})
    |=> r_reg.st == ST_USER && !r_reg.boot) else $error("wrong mode after reset");
  chk_ready_delay: assert property (@(posedge core_clk) disable iff (!nrst)
    r_reg.st == ST_WAIT_HIGH && $past(r_reg.st) == ST_WAIT_READY |-> $past(r_reg.st, READY_CYCLES) == ST_WAIT_READY
    && $past(r_reg.st, READY_CYCLES + 16'h0001) == ST_SETTLE) else $error("ready wait has wrong length");
  chk_divisor_load: assert property (@(posedge core_clk) disable iff (!nrst)
    (r_reg.st == ST_MEASURE && r_reg.rxd_sync[1] && r_reg.cnt != 16'h0 && r_reg.div_acc != 16'h0 && !watchdog_overflow)
    |=> r_reg.divisor == $past(r_reg.div_acc) && r_reg.st == ST_SEND_ADJ) else $error("divisor not loaded");
  chk_adjust_byte: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(r_reg.st == ST_SEND_ADJ) && !watchdog_overflow |-> ##[1:3] (r_reg.tx_start && r_reg.tx_byte == BYTE_ADJ))
    else $error("adjust byte not sent");
  chk_sync_reply: assert property (@(posedge core_clk) disable iff (!nrst)
    (r_reg.st == ST_WAIT_SYNC && bus.rx_valid && bus.rx_data == BYTE_SYNC && !watchdog_overflow)
    |=> r_reg.tx_pend && r_reg.tx_byte == BYTE_ACK ##1 r_reg.st == ST_LEN_HI) else $error("no reply to sync");
  chk_length_high: assert property (@(posedge core_clk) disable iff (!nrst)
    (r_reg.st == ST_LEN_HI && bus.rx_valid && !watchdog_overflow)
    |=> r_reg.length[15:8] == $past(bus.rx_data) && r_reg.tx_byte == $past(bus.rx_data)) else $error("length byte");
  chk_ram_store: assert property (@(posedge core_clk) disable iff (!nrst)
    (r_reg.st == ST_LOAD && bus.rx_valid && r_reg.index < 16'(BOOT_RAM_DEPTH))
    |=> r_reg.ram_we && r_reg.ram_wdata == $past(bus.rx_data) && r_reg.ram_waddr == $past(r_reg.index[BOOT_RAM_AW-1:0]))
    else $error("program byte not stored");
  chk_erase_fail: assert property (@(posedge core_clk) disable iff (!nrst)
    (r_reg.st == ST_ERASE_WAIT && flash_erase_fail && !watchdog_overflow)
    |=> r_reg.tx_byte == BYTE_FAIL && r_reg.erase_err ##[1:8] r_reg.st == ST_DRAIN) else $error("erase fail code");
  chk_branch_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(r_reg.branch) |-> !r_reg.rx_en && !r_reg.tx_en && r_reg.txd_oe && bus.txd && r_reg.divisor != 16'h0000)
    else $error("serial not parked at branch");
  chk_erase_masked: assert property (@(posedge core_clk) disable iff (!nrst)
    r_reg.erase_req |-> r_reg.irq_mask) else $error("interrupts open during erase");
  chk_watchdog_exit: assert property (@(posedge core_clk) disable iff (!nrst)
    (in_boot(r_reg.st) && watchdog_overflow) |=> r_reg.st == ST_EXIT && !r_reg.boot && !r_reg.txd_oe)
    else $error("watchdog did not end boot");
endmodule // sbl_loader

// >>> sbl_host_model.sv
// Host model of the boot link: 8N1 bytes, lsb first, on the receive pin.
// Assumes the bit period in core clocks is BIT.
module sbl_host_model #(parameter int BIT = 90) (
  input wire logic core_clk,
  output logic rxd_pin,
  input wire logic txd_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stop_zeros = 1'b0;
  // The line idles high, so reset always ends with it high.
  initial rxd_pin = 1'b1;
  // Start bit, eight data bits, one stop bit, no parity.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_pin <= f[i];
      repeat (BIT) @(posedge core_clk);
    end
  endtask
  // Zero bytes back to back until the caller sees the adjust byte.
  task automatic zeros();
    @(posedge core_clk);
    while (!stop_zeros) send(8'h00);
  endtask
  // Samples each data bit at its middle; returns at the middle of the stop bit.
  task automatic recv(output logic [7:0] b);
    @(negedge txd_pin_o);
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge core_clk);
      if (i < 8) b[i] = txd_pin_o;
    end
  endtask
endmodule // sbl_host_model

// >>> tb.sv
// Testbench of the boot loader: full boot exchange plus register reads.
// Assumes the host model and a flash that erases at once.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbl_pkg::*;
  // A short bit time keeps the run brief; the 16-bit divisor also spans the slow host rates.
  localparam int BIT = 90;
  logic core_clk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic flash_erase_done = 1'b0, wb_ack_o, rxd_pin, txd_pin_o, txd_pin_oe;
  logic flash_erase_req, interrupt_mask, boot_active, branch_go;
  logic [WB_AW-1:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'h0;
  logic [2:0] mode_pins = 3'h3;
  logic wdog = 1'b0, erase_fail = 1'b0;
  logic [23:0] branch_addr;
  logic [7:0] prog [3] = '{8'hA5, 8'h3C, 8'h81};
  int failures = 0, n_tests = 0;
  always #2.5 core_clk = ~core_clk;
  sbl_loader dut (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .rxd_pin, .txd_pin_o, .txd_pin_oe, .mode_select_pins(mode_pins),
    .flash_write_enable_pin(1'b1), .watchdog_overflow(wdog), .flash_has_data(1'b1), .flash_erase_done,
    .flash_erase_fail(erase_fail), .flash_erase_req, .interrupt_mask, .boot_active, .branch_go, .branch_addr);
  sbl_host_model #(.BIT(BIT)) host (.core_clk, .rxd_pin, .txd_pin_o);
  // -------------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle held until ack is sampled high at a rising edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // The reply can start inside our stop bit, so listen while sending.
  task automatic xfer(input logic [7:0] b, input logic [7:0] e);
    logic [7:0] r;
    fork
      host.send(b);
      host.recv(r);
    join
    check(r, e);
  endtask
  // Mid-run reset, held long enough to leave boot mode cleanly.
  task automatic restart(input logic [2:0] pins);
    nrst <= 1'b0;
    mode_pins <= pins;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
  endtask
  // Zero stream until the adjust byte returns, a quiet gap, then the sync exchange.
  task automatic match_rate();
    logic [7:0] r;
    host.stop_zeros = 1'b0;
    fork
      host.zeros();
      begin
        host.recv(r);
        host.stop_zeros = 1'b1;
      end
    join
    check(r, BYTE_ADJ);
    repeat (4 * BIT) @(posedge core_clk);
    xfer(BYTE_SYNC, BYTE_ACK);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Flash model finishes one cycle after the request; mask must hold meanwhile.
  always @(posedge core_clk) begin
    flash_erase_done <= flash_erase_req & ~flash_erase_done;
    if (flash_erase_req) check(interrupt_mask, 1);
  end
  initial begin
    repeat (50000) @(posedge core_clk);
    failures++;
    complete_run();
  end
  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    logic [7:0] r;
    logic [31:0] q;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    match_rate();
    check(boot_active, 1);
    xfer(8'h00, 8'h00);
    xfer(8'h03, 8'h03);
    for (int i = 0; i < 3; i++) xfer(prog[i], prog[i]);
    $display("Test handshake and load done");
    host.recv(r);
    check(r, BYTE_ACK);
    for (int i = 0; i < 4 * BIT && branch_go !== 1'b1; i++) @(posedge core_clk);
    check({branch_go, txd_pin_o, txd_pin_oe, interrupt_mask}, 4'hE);
    check(branch_addr, BOOT_RAM_BASE);
    wb(1'b0, REG_DIVISOR, 0, q);
    check(q[15:0] >= BIT - 1 && q[15:0] <= BIT + 1, 1);
    wb(1'b1, REG_RAM_ADDR, 1, q);
    wb(1'b0, REG_RAM_DATA, 0, q);
    check(q[7:0], prog[1]);
    wb(1'b0, REG_LENGTH, 0, q);
    check(q, 32'h00030003);
    wb(1'b0, REG_STATUS, 0, q);
    check(q, 32'h0000002D);
    wb(1'b0, 8'h20, 0, q);
    check(q, 0);
    $display("Test branch and registers done");
    restart(3'h3);
    erase_fail <= 1'b1;
    match_rate();
    xfer(8'h00, 8'h00);
    xfer(8'h00, 8'h00);
    host.recv(r);
    check(r, BYTE_FAIL);
    repeat (BIT) @(posedge core_clk);
    check({branch_go, interrupt_mask, boot_active}, 3'h3);
    wb(1'b0, REG_STATUS, 0, q);
    check(q, 32'h0000001D);
    $display("Test erase failure done");
    restart(3'h3);
    erase_fail <= 1'b0;
    repeat (200) @(posedge core_clk);
    wdog <= 1'b1;
    @(posedge core_clk);
    wdog <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({boot_active, txd_pin_oe, interrupt_mask}, 0);
    wb(1'b0, REG_STATUS, 0, q);
    check(q, 32'h00000002);
    restart(3'h7);
    repeat (8) @(posedge core_clk);
    check({boot_active, txd_pin_oe, interrupt_mask}, 0);
    wb(1'b0, REG_STATUS, 0, q);
    check(q, 0);
    $display("Test watchdog and user mode done");
    complete_run();
  end
endmodule // tb
